/* File: src/vif_defs.svh */
// Purpose: Constants of the video input front end
// Assumes: Included by bare name from design and bench files
// Notes:   Offsets are word indices, compared with bus address bits 7:2
`ifndef VIF_DEFS_SVH
`define VIF_DEFS_SVH

// Register word offsets (bus address bits 7:2)
`define VIF_ADR_CTRL      6'h00
`define VIF_ADR_TIM       6'h01
`define VIF_ADR_STAT      6'h02
`define VIF_ADR_FRMS      6'h03

// Control register fields
`define VIF_CF_FMT_LSB    5'h00
`define VIF_CF_STD_LSB    5'h03
`define VIF_CF_L1280      5'h05
`define VIF_CF_ORDB       5'h06
`define VIF_CF_HDIR       5'h07
`define VIF_CF_VDIR       5'h08
`define VIF_CF_CLKF       5'h09
`define VIF_CF_HSH        5'h0a
`define VIF_CF_VSH        5'h0b
`define VIF_CF_DEL        5'h0c
`define VIF_CF_EN         5'h0d
`define VIF_CTRL_RST      32'h0000_2180
`define VIF_CTRL_MASK     32'h0000_3fff

// Timing register fields and reset
`define VIF_TF_HSKIP_LSB  5'h00
`define VIF_TF_VSKIP_LSB  5'h10
`define VIF_TIM_RST       32'h0000_0000
`define VIF_TIM_MASK      32'h03ff_0fff

// Status register fields
`define VIF_SF_FIELD      5'h00
`define VIF_SF_VBLANK     5'h01
`define VIF_SF_LACT       5'h02
`define VIF_SF_LINE_LSB   5'h10

// Panel and display geometry
`define VIF_LAST_COL      10'h3bd
`define VIF_LAST_ROW      8'hef
`define VIF_DISP_W        10'h140
`define VIF_DISP_H        10'h0f0

// Cycles per active line and source pixels per line
`define VIF_CYC_RGB24     12'h140
`define VIF_CYC_RGB8      12'h3c0
`define VIF_CYC_1440      12'h5a0
`define VIF_CYC_1280      12'h500
`define VIF_W_RGB         10'h140
`define VIF_W_720         10'h2d0
`define VIF_W_640         10'h280

// Active lines per field and top crop
`define VIF_LN_NTSC       10'h0f0
`define VIF_LN_PAL280     10'h118
`define VIF_LN_PAL288     10'h120
`define VIF_TOP_PAL280    10'h014
`define VIF_TOP_PAL288    10'h018

// Embedded code preamble
`define VIF_PRE_FF        8'hff
`define VIF_PRE_00        8'h00

// Colour conversion weights, scaled by 256
`define VIF_K_RCR         20'sh00167
`define VIF_K_GCB         20'sh00058
`define VIF_K_GCR         20'sh000b7
`define VIF_K_BCB         20'sh001c6
`define VIF_K_MID         20'sh00080

`endif

/* File: src/vif_pkg.sv */
// Purpose: Types of the video input front end
// Assumes: Nothing beyond the tool's SystemVerilog support
// Notes:   Numbers live in vif_defs.svh
package vif_pkg;

    // Input formats, as written to the control register
    typedef enum logic [2:0] {
        VIF_FMT_RGB8_HV,
        VIF_FMT_RGB8_DE,
        VIF_FMT_RGB24_HV,
        VIF_FMT_RGB24_DE,
        VIF_FMT_Y601,
        VIF_FMT_Y656
    } vif_fmt_e;

    // Field standards
    typedef enum logic [1:0] {
        VIF_STD_NTSC,
        VIF_STD_PAL280,
        VIF_STD_PAL288
    } vif_std_e;

    // One pixel of three components
    typedef struct packed {
        logic [7:0] b;
        logic [7:0] g;
        logic [7:0] r;
    } vif_rgb_s;

    // Pins of the video link
    typedef struct packed {
        logic        pclk;
        logic        hs;
        logic        vs;
        logic        de;
        logic [23:0] din;
    } vif_pins_s;

    // Pixel as handed to the panel drivers
    typedef struct packed {
        vif_rgb_s   rgb;
        logic [9:0] col;
        logic [7:0] row;
        logic       first;
    } vif_pix_s;

endpackage

/* File: src/vif_front.sv */
// Purpose: Video input front end: samples the pixel link, decodes RGB and
//          luma/chroma formats, finds fields and lines, orders columns/rows
// Assumes: clk_sys well above the pixel clock (at least three samples per
//          half period); classic Wishbone register slave
// Notes:   Function
// Function
// [RULE1] Column order follows horizontal direction bit
// [RULE2] Row order follows vertical direction bit
// [RULE3] Twenty two input formats selectable; the code selects six
// [RULE4] RGB 8-8-8 and luma/chroma 4:2:2 decoded
// [RULE5] Chroma byte order A or B
// [RULE6] Sync mode ignores data enable
// [RULE7] Enable mode ignores both syncs
// [RULE8] Host clocks RGB at 6.4 or 27 MHz
// [RULE9] Clock edge and sync polarities configurable
// [RULE10] 601 input uses 8-bit path only
// [RULE11] 601: NTSC/PAL, 1440 or 1280 cycles
// [RULE12] Host clocks 601 at 24.54/27 MHz
// [RULE13] Frame is odd then even field
// [RULE14] Coincident sync edges start odd field
// [RULE15] Vsync edge with hsync high: even
// [RULE16] Active lines 240, 280 or 288
// [RULE17] 656 timing from embedded codes only
// [RULE18] Code byte: 1, field, vertical, horizontal
// [RULE19] Field flag 0 odd, 1 even
// [RULE20] Vertical flag 1 means blanking line
// [RULE21] Horizontal flag 0 start, 1 end
// [RULE22] Resize 720 or 640 wide to 320x240
// [RULE23] Enable mode takes data only when enabled
// [RULE24] Parallel lanes red, green, blue low-up
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`include "vif_defs.svh"
`timescale 1ns/100ps

module vif_front (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic         pixel_clock_in,
    input  wire logic         horizontal_sync_in,
    input  wire logic         vertical_sync_in,
    input  wire logic         data_enable_in,
    input  wire logic [23:0]  video_data_in,
    output logic              pix_valid,
    output vif_pkg::vif_pix_s pix_out,
    output logic              frame_start,
    output logic              field_even
);
    import vif_pkg::*;

    // Three-stage synchronisers for all link pins
    vif_pins_s   sync1_reg, sync2_reg, sync3_reg;
    vif_pins_s   pins_now;
    // Registers
    logic [31:0] ctrl_reg;                  // Control register
    logic [31:0] tim_reg;                   // Window offsets
    logic [15:0] frames_reg;                // Frames seen
    // Link timing state
    logic        pclk_lvl_reg;              // Accepted pixel clock level
    logic        hs_prev_reg, vs_prev_reg, de_prev_reg;
    logic [11:0] cyc_reg;                   // Cycles since line marker
    logic [9:0]  line_reg;                  // Lines since frame marker
    logic        vblank_reg;                // Embedded vertical flag
    logic        in_line_reg;               // Between start and end codes
    logic [23:0] hist_reg;                  // Last three bytes
    logic [1:0]  ph_reg;                    // Byte phase in pixel group
    logic [7:0]  b0_reg, b1_reg, b2_reg;    // Captured group bytes
    logic [9:0]  acc_reg;                   // Decimation accumulator
    logic [8:0]  xo_reg;                    // Output pixel in line

    assign pins_now = '{pclk: pixel_clock_in, hs: horizontal_sync_in,
                        vs: vertical_sync_in, de: data_enable_in,
                        din: video_data_in};

    // Pin synchronisers; stage one feeds only stage two
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= pins_now;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Control field decode
    vif_fmt_e    fmt;
    vif_std_e    std;
    logic        en, hdir, vdir, ordb, l1280;
    logic        is_rgb8, is_rgb24, is_de, is_hv, is_601, is_656, is_ycc;
    logic [11:0] src_cyc, h_lo, h_skip;
    logic [9:0]  src_w, src_lines, vtop, v_skip;
    assign fmt    = vif_fmt_e'(ctrl_reg[`VIF_CF_FMT_LSB +: 3]);
    assign std    = vif_std_e'(ctrl_reg[`VIF_CF_STD_LSB +: 2]);
    assign en     = ctrl_reg[`VIF_CF_EN];
    assign hdir   = ctrl_reg[`VIF_CF_HDIR];
    assign vdir   = ctrl_reg[`VIF_CF_VDIR];
    assign ordb   = ctrl_reg[`VIF_CF_ORDB];
    assign l1280  = ctrl_reg[`VIF_CF_L1280];
    assign h_skip = tim_reg[`VIF_TF_HSKIP_LSB +: 12];
    assign v_skip = tim_reg[`VIF_TF_VSKIP_LSB +: 10];

    // Format properties
    always_comb begin
        is_rgb8  = 1'b0;
        is_rgb24 = 1'b0;
        is_de    = 1'b0;
        is_601   = 1'b0;
        is_656   = 1'b0;
        // [RULE3] format select
        unique case (fmt)
            VIF_FMT_RGB8_HV:  is_rgb8 = 1'b1;
            VIF_FMT_RGB8_DE:  begin
                is_rgb8 = 1'b1;
                is_de   = 1'b1;
            end
            VIF_FMT_RGB24_HV: is_rgb24 = 1'b1;
            VIF_FMT_RGB24_DE: begin
                is_rgb24 = 1'b1;
                is_de    = 1'b1;
            end
            VIF_FMT_Y601:     is_601 = 1'b1;
            VIF_FMT_Y656:     is_656 = 1'b1;
            default:          ;       // Codes 6 and 7 decode nothing
        endcase
    end
    assign is_ycc = is_601 | is_656;
    assign is_hv  = (is_rgb8 | is_rgb24 | is_601) & ~is_de;

    // Line length, source width and field height per format
    always_comb begin
        // [RULE11] 601 line length, 656 fixed 1440
        if (is_rgb24) begin
            src_cyc = `VIF_CYC_RGB24;
            src_w   = `VIF_W_RGB;
        end else if (is_rgb8) begin
            src_cyc = `VIF_CYC_RGB8;
            src_w   = `VIF_W_RGB;
        // [RULE22] 640 or 720 source pixels
        end else if (is_601 && l1280) begin
            src_cyc = `VIF_CYC_1280;
            src_w   = `VIF_W_640;
        end else begin
            src_cyc = `VIF_CYC_1440;
            src_w   = `VIF_W_720;
        end
        // [RULE16] lines per field
        if (is_ycc && std == VIF_STD_PAL280) begin
            src_lines = `VIF_LN_PAL280;
            vtop      = `VIF_TOP_PAL280;
        end else if (is_ycc && std == VIF_STD_PAL288) begin
            src_lines = `VIF_LN_PAL288;
            vtop      = `VIF_TOP_PAL288;
        end else begin
            src_lines = `VIF_LN_NTSC;
            vtop      = 10'h000;
        end
        h_lo = is_656 ? 12'h001 : h_skip;
    end

    // [RULE9] polarity of clock edge and syncs
    logic pe, agree, hs_a, vs_a, de_a, hs_edge, vs_edge, de_rise, de_fall;
    logic [7:0] d8;
    assign agree   = (sync2_reg.pclk == sync3_reg.pclk);
    assign pe      = en & agree & (sync3_reg.pclk != pclk_lvl_reg)
                   & (sync3_reg.pclk != ctrl_reg[`VIF_CF_CLKF]);
    assign hs_a    = ~(sync3_reg.hs ^ ctrl_reg[`VIF_CF_HSH]);
    assign vs_a    = ~(sync3_reg.vs ^ ctrl_reg[`VIF_CF_VSH]);
    assign de_a    = sync3_reg.de ^ ctrl_reg[`VIF_CF_DEL];
    assign hs_edge = hs_a & ~hs_prev_reg;
    assign vs_edge = vs_a & ~vs_prev_reg;
    assign de_rise = de_a & ~de_prev_reg;
    assign de_fall = ~de_a & de_prev_reg;
    // [RULE10] 8-bit path, bit 7 most significant
    assign d8      = sync3_reg.din[7:0];

    // Embedded code: preamble then flag byte with bit 7 set
    logic xy_hit;
    // [RULE17] timing from code stream
    assign xy_hit = is_656 & (hist_reg == {`VIF_PRE_FF, `VIF_PRE_00, `VIF_PRE_00})
                  & d8[7];

    // Accepted clock level and sampled sync history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pclk_lvl_reg <= 1'b0;
            hs_prev_reg  <= 1'b0;
            vs_prev_reg  <= 1'b0;
            de_prev_reg  <= 1'b0;
            hist_reg     <= '0;
        end else begin
            if (agree) begin
                pclk_lvl_reg <= sync3_reg.pclk;
            end
            if (pe) begin
                hs_prev_reg <= hs_a;
                vs_prev_reg <= vs_a;
                de_prev_reg <= de_a;
                hist_reg    <= {hist_reg[15:0], d8};
            end
        end
    end

    // Frame, line and cycle tracking
    logic frame_ev, gap_ev;
    assign gap_ev = is_de & ~de_a & (cyc_reg == {src_cyc[10:0], 1'b0});
    always_comb begin
        frame_ev = 1'b0;
        if (pe) begin
            if (is_hv) begin
                frame_ev = vs_edge;
            end else if (is_de) begin
                frame_ev = gap_ev | (de_fall & (line_reg + 10'h001 == src_lines));
            end else if (xy_hit) begin
                frame_ev = ~d8[4] & ~d8[5] & vblank_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cyc_reg     <= 12'hfff;         // No line marker seen yet
            line_reg    <= '0;
            vblank_reg  <= 1'b1;
            in_line_reg <= 1'b0;
            field_even  <= 1'b0;
        end else if (pe) begin
            if (cyc_reg != 12'hfff) begin
                cyc_reg <= cyc_reg + 12'h001;
            end
            if (is_hv) begin
                // [RULE6] line from horizontal sync
                if (hs_edge) begin
                    cyc_reg <= '0;
                    if (line_reg != 10'h3ff) begin
                        line_reg <= line_reg + 10'h001;
                    end
                end
                if (vs_edge) begin
                    line_reg <= '0;
                    // [RULE13] odd then even field
                    // [RULE14] coincident edges: odd
                    // [RULE15] hsync still high: even
                    if (!is_601 || hs_edge) begin
                        field_even <= 1'b0;
                    end else if (!hs_a) begin
                        field_even <= 1'b1;
                    end
                end
            end else if (is_de) begin
                // [RULE7] line and frame from enable
                field_even <= 1'b0;
                if (de_rise) begin
                    cyc_reg <= '0;
                end
                if (frame_ev) begin
                    line_reg <= '0;
                end else if (de_fall) begin
                    line_reg <= line_reg + 10'h001;
                end
            end else if (xy_hit) begin
                // [RULE18] flag byte fields
                // [RULE19] field flag
                field_even <= d8[6];
                // [RULE20] vertical blanking flag
                vblank_reg <= d8[5];
                // [RULE21] start or end code
                if (!d8[4]) begin
                    cyc_reg     <= '0;
                    in_line_reg <= ~d8[5];
                    if (frame_ev) begin
                        line_reg <= '0;
                    end
                end else begin
                    in_line_reg <= 1'b0;
                    if (in_line_reg) begin
                        line_reg <= line_reg + 10'h001;
                    end
                end
            end
        end
    end

    // Active window and display row
    logic       act, act_v;
    logic [9:0] src_line, drow;
    always_comb begin
        src_line = is_hv ? line_reg - v_skip : line_reg;
        drow     = src_line - vtop;
        act_v    = (src_line >= vtop) && (drow < `VIF_DISP_H)
                 && (src_line < src_lines) && !(is_hv && line_reg < v_skip);
        if (is_de) begin
            // [RULE23] data only while enabled
            act = de_a;
        end else begin
            act = (cyc_reg >= h_lo) && (cyc_reg - h_lo < src_cyc)
                && (!is_656 || in_line_reg);
        end
    end

    // Byte phase within a pixel group
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ph_reg <= '0;
            b0_reg <= '0;
            b1_reg <= '0;
            b2_reg <= '0;
        end else if (pe) begin
            if (!act || is_rgb24 || (is_rgb8 && ph_reg == 2'h2)) begin
                ph_reg <= '0;
            end else begin
                ph_reg <= ph_reg + 2'h1;
            end
            unique case (ph_reg)
                2'h0: b0_reg <= d8;
                2'h1: b1_reg <= d8;
                2'h2: b2_reg <= d8;
                2'h3: ;
            endcase
        end
    end

    // Luma/chroma to RGB with clamping
    function automatic vif_rgb_s ycc2rgb(input logic [7:0] y,
                                         input logic [7:0] cb,
                                         input logic [7:0] cr);
        logic signed [19:0] yy, dcb, dcr, rr, gg, bb;
        vif_rgb_s           o;
        yy  = signed'({12'h000, y});
        dcb = signed'({12'h000, cb}) - `VIF_K_MID;
        dcr = signed'({12'h000, cr}) - `VIF_K_MID;
        rr  = yy + ((`VIF_K_RCR * dcr) >>> 8);
        gg  = yy - ((`VIF_K_GCB * dcb + `VIF_K_GCR * dcr) >>> 8);
        bb  = yy + ((`VIF_K_BCB * dcb) >>> 8);
        o.r = (rr < 0) ? 8'h00 : ((rr > 20'sh000ff) ? 8'hff : rr[7:0]);
        o.g = (gg < 0) ? 8'h00 : ((gg > 20'sh000ff) ? 8'hff : gg[7:0]);
        o.b = (bb < 0) ? 8'h00 : ((bb > 20'sh000ff) ? 8'hff : bb[7:0]);
        return o;
    endfunction

    // Source pixel assembly
    logic       src_pix;
    vif_rgb_s   src_rgb;
    logic [7:0] cb, cr;
    always_comb begin
        src_pix = 1'b0;
        src_rgb = '0;
        // [RULE5] chroma order A or B
        cb = ordb ? b2_reg : b0_reg;
        cr = ordb ? b0_reg : b2_reg;
        // [RULE4] RGB and 4:2:2 decode
        if (is_rgb24) begin
            src_pix = 1'b1;
            // [RULE24] red low, green middle, blue high
            src_rgb = '{b: sync3_reg.din[23:16], g: sync3_reg.din[15:8],
                        r: sync3_reg.din[7:0]};
        end else if (is_rgb8) begin
            src_pix = (ph_reg == 2'h2);
            src_rgb = '{b: d8, g: b1_reg, r: b0_reg};
        end else if (ph_reg == 2'h2) begin
            src_pix = 1'b1;
            src_rgb = ordb ? ycc2rgb(b1_reg, d8, b0_reg) : ycc2rgb(b1_reg, b0_reg, d8);
        end else if (ph_reg == 2'h3) begin
            src_pix = 1'b1;
            src_rgb = ycc2rgb(d8, cb, cr);
        end
        src_pix = src_pix & pe & act & act_v;
    end

    // [RULE22] horizontal decimation to 320
    logic [10:0] acc_sum;
    logic        emit;
    assign acc_sum = {1'b0, acc_reg} + {1'b0, `VIF_DISP_W};
    assign emit    = src_pix && (acc_sum >= {1'b0, src_w})
                   && ({1'b0, xo_reg} < `VIF_DISP_W);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= '0;
            xo_reg  <= '0;
        end else if (pe && !act) begin
            acc_reg <= '0;
            xo_reg  <= '0;
        end else if (src_pix) begin
            acc_reg <= emit || acc_sum >= {1'b0, src_w}
                     ? acc_sum[9:0] - src_w : acc_sum[9:0];
            if (emit) begin
                xo_reg <= xo_reg + 9'h001;
            end
        end
    end

    // Pixel output towards the column and row drivers
    logic [9:0] xo3;
    assign xo3 = {xo_reg, 1'b0} + {1'b0, xo_reg};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pix_valid   <= 1'b0;
            pix_out     <= '0;
            frame_start <= 1'b0;
        end else begin
            pix_valid   <= emit;
            frame_start <= frame_ev;
            if (emit) begin
                pix_out.rgb   <= src_rgb;
                // [RULE1] column order
                pix_out.col   <= hdir ? xo3 : `VIF_LAST_COL - xo3;
                // [RULE2] row order
                pix_out.row   <= vdir ? drow[7:0] : `VIF_LAST_ROW - drow[7:0];
                pix_out.first <= (xo_reg == 9'h000);
            end
        end
    end

    // Frame counter for status
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            frames_reg <= '0;
        end else if (frame_ev) begin
            frames_reg <= frames_reg + 16'h0001;
        end
    end

    // Register bus: single-wait ack, write on the acked cycle
    logic [31:0] wmask, rdata;
    logic        req;
    assign req   = wb_cyc_i & wb_stb_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                    {8{wb_sel_i[0]}}};
    always_comb begin
        unique case (wb_adr_i[7:2])
            `VIF_ADR_CTRL: rdata = ctrl_reg;
            `VIF_ADR_TIM:  rdata = tim_reg;
            `VIF_ADR_STAT: begin
                rdata                       = '0;
                rdata[`VIF_SF_FIELD]        = field_even;
                rdata[`VIF_SF_VBLANK]       = vblank_reg;
                rdata[`VIF_SF_LACT]         = act;
                rdata[`VIF_SF_LINE_LSB +: 10] = line_reg;
            end
            `VIF_ADR_FRMS: rdata = {16'h0000, frames_reg};
            default:       rdata = '0;    // Unmapped reads zero
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req && !wb_ack_o) begin
                wb_dat_o <= rdata;
            end
        end
    end

    // Writable registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `VIF_CTRL_RST;
            tim_reg  <= `VIF_TIM_RST;
        end else if (req && wb_we_i && wb_ack_o) begin
            if (wb_adr_i[7:2] == `VIF_ADR_CTRL) begin
                ctrl_reg <= ((ctrl_reg & ~wmask) | (wb_dat_i & wmask)) & `VIF_CTRL_MASK;
            end
            if (wb_adr_i[7:2] == `VIF_ADR_TIM) begin
                tim_reg <= ((tim_reg & ~wmask) | (wb_dat_i & wmask)) & `VIF_TIM_MASK;
            end
        end
    end

endmodule

/* File: test/vif_front_properties.sv */
// Purpose: Port checks of the video front end
// Assumes: Bound to vif_front
// Notes:   Bus answer and pixel output timing
`timescale 1ns/100ps
module vif_front_properties (
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic              pix_valid,
    input wire vif_pkg::vif_pix_s pix_out,
    input wire logic              frame_start
);
    import vif_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack");
    chk_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    chk_col_grid:
    assert property (pix_valid |-> pix_out.col <= 10'h3bd && pix_out.col % 3 == 0) else $error("col");
    chk_first_col:
    assert property (pix_valid && pix_out.first |-> pix_out.col inside {10'h000, 10'h3bd})
    else $error("first col");
    chk_row_span:
    assert property (pix_valid |-> pix_out.row <= 8'hef) else $error("row");
    chk_pix_gap:
    assert property (pix_valid |=> !pix_valid) else $error("pixel burst");
    chk_out_hold:
    assert property (!pix_valid |-> $stable(pix_out)) else $error("pixel moved");
    chk_frame_pulse:
    assert property (frame_start |=> !frame_start) else $error("frame pulse");
    cover property (pix_valid && pix_out.first);
    cover property (frame_start);
    cover property (wb_ack_o);
endmodule
bind vif_front vif_front_properties chk (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pix_valid(pix_valid), .pix_out(pix_out),
    .frame_start(frame_start));

/* File: test/vif_video_source.sv */
// Purpose: Host video source on the pixel link
// Assumes: 125 ns pixel clock, data taken on its rising edge
// Notes:   Clock stands still between runs; the two lines of a run follow back to back
`timescale 1ns/100ps
module vif_video_source (
    input  wire logic          de_mode,
    output vif_pkg::vif_pins_s pins
);
    import vif_pkg::*;
    initial pins = {4'b0110, 24'h0};
    // One line of 320 pixels, opening a frame in sync mode if asked
    task automatic send_line(input logic vs_on);
        logic act;
        for (int k = -2; k < 322; k++) begin
            // Pixels start on the edge after the sync edge
            act = k >= 1 && k < 321;
            pins.pclk = 1'b0;
            pins.din = act ? {8'h30, 8'h20, 8'(k - 1)} : ~pins.din;
            pins.de = de_mode & act;
            pins.hs = de_mode ? k[1] : !(k >= 0 && k < 4);
            pins.vs = de_mode ? k[2] : !(vs_on && k >= 0 && k < 4);
            #62.5 pins.pclk = 1'b1;
            #62.5;
        end
    endtask
endmodule

/* File: test/vif_front_bench.sv */
// Purpose: Self-checking bench of the video front end
// Assumes: Source model drives the pixel link
// Notes:   Counts pixels and checks the first pixel of each run except the disabled run, which has none
`include "vif_defs.svh"
`timescale 1ns/100ps
module vif_front_bench;
    import vif_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, de_mode = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, row0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, pix_valid, frame_start, field_even;
    vif_pins_s pins;
    vif_pix_s pix_out, fpix;
    int fail_count = 0, cmp_count = 0, npix = 0, nfirst = 0, nfs = 0;
    vif_front uut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pixel_clock_in(pins.pclk),
        .horizontal_sync_in(pins.hs), .vertical_sync_in(pins.vs), .data_enable_in(pins.de),
        .video_data_in(pins.din), .pix_valid(pix_valid), .pix_out(pix_out),
        .frame_start(frame_start), .field_even(field_even));
    vif_video_source src (.de_mode(de_mode), .pins(pins));
    always #5 clk_sys = ~clk_sys;
    // Tally pixels and frame pulses
    always @(posedge clk_sys) begin
        if (pix_valid) npix++;
        if (pix_valid && pix_out.first && nfirst++ == 0) fpix = pix_out;
        if (frame_start) nfs++;
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One classic cycle, held until ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic check_regs;
        wb(1'b0, 8'h00, 32'h0);
        cmp("ctrl reset", `VIF_CTRL_RST, rd);
        wb(1'b0, 8'h04, 32'h0);
        cmp("tim reset", `VIF_TIM_RST, rd);
        wb(1'b1, 8'h20, 32'hffff_ffff);
        wb(1'b0, 8'h20, 32'h0);
        cmp("unmapped", 32'h0, rd);
    endtask
    // Configure, then two lines, the first opening a frame in sync mode
    task automatic send(input logic [31:0] ctrl, input logic de);
        wb(1'b1, 8'h00, ctrl);
        de_mode = de;
        {npix, nfirst, nfs} = '0;
        src.send_line(1'b1);
        src.send_line(1'b0);
        repeat (20) @(posedge clk_sys);
    endtask
    task automatic ycc_run;
        send(32'h0000_2184, 1'b0);
        cmp("ycc rgb", 32'h0000_8700, fpix.rgb);
        cmp("frames", 32'd1, nfs);
        cmp("field", 32'd0, field_even);
    endtask
    task automatic hv_forward;
        send(32'h0000_2182, 1'b0);
        cmp("pixels", 32'd640, npix);
        cmp("first col", 32'd0, fpix.col);
        cmp("first rgb", 32'h0030_2000, fpix.rgb);
        cmp("frames", 32'd1, nfs);
        cmp("field", 32'd0, field_even);
        row0 = fpix.row;
    endtask
    task automatic hv_reverse;
        send(32'h0000_2002, 1'b0);
        cmp("first col", 32'h3bd, fpix.col);
        cmp("first row", `VIF_LAST_ROW - row0, fpix.row);
    endtask
    task automatic de_run;
        send(32'h0000_2183, 1'b1);
        cmp("pixels", 32'd640, npix);
        cmp("first col", 32'd0, fpix.col);
    endtask
    task automatic off_run;
        send(32'h0000_0182, 1'b0);
        cmp("pixels", 32'd0, npix);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        check_regs;
        ycc_run;
        hv_forward;
        hv_reverse;
        de_run;
        off_run;
        give_verdict;
    end
    initial begin
        #600000;
        fail_count++;
        give_verdict;
    end
endmodule
